//--- hdl/mrsl_pkg.sv
// mrsl_pkg: register map, field positions, reset values and timing
// for the single-module reset and strap latch block.
// assumes a 200 MHz pclk and a 32-bit APB register bus.
package mrsl_pkg;

  // clock and reset durations
  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned XCVR_RST_US = 110;
  localparam int unsigned EMU_RST_US = 1;
  localparam int unsigned XCVR_RST_CYC = XCVR_RST_US * CLK_MHZ;
  localparam int unsigned EMU_RST_CYC = EMU_RST_US * CLK_MHZ;
  localparam int unsigned CNT_W = 16;

  // register byte offsets
  localparam logic [7:0] RESET_CONTROL_OFS = 8'h00;
  localparam logic [7:0] POWER_MGMT_OFS = 8'h04;
  localparam logic [7:0] PORT_A_BASIC_OFS = 8'h08;
  localparam logic [7:0] PORT_B_BASIC_OFS = 8'h0C;
  localparam logic [7:0] EMU_BASIC_OFS = 8'h10;
  localparam logic [7:0] MEM_COMMAND_OFS = 8'h14;
  localparam logic [7:0] INDICATOR_CFG_OFS = 8'h18;
  localparam logic [7:0] PORT_A_MODE_OFS = 8'h1C;
  localparam logic [7:0] STRAP_STATUS_OFS = 8'h20;

  // reset control register fields
  localparam int unsigned RC_DIGITAL_BIT = 0;
  localparam int unsigned RC_PORT_A_BIT = 1;
  localparam int unsigned RC_PORT_B_BIT = 2;
  localparam int unsigned RC_EMU_BIT = 3;
  // power management register fields
  localparam int unsigned PM_EMU_BIT = 0;
  localparam int unsigned PM_PD_A_BIT = 1;
  localparam int unsigned PM_PD_B_BIT = 2;
  // basic control register fields
  localparam int unsigned BC_RESET_BIT = 15;
  localparam int unsigned BC_NEG_BIT = 12;
  localparam int unsigned BC_SPEED_BIT = 13;
  localparam int unsigned BC_DUPLEX_BIT = 8;
  localparam int unsigned BC_LOOP_BIT = 14;
  // memory command register fields
  localparam int unsigned MC_RELOAD_BIT = 0;
  // indicator config fields
  localparam int unsigned IC_EN_LSB = 0;
  localparam int unsigned IC_FUN_LSB = 8;
  localparam int unsigned IND_EN_W = 8;
  localparam int unsigned IND_FUN_W = 2;
  // port a mode register fields
  localparam int unsigned PM_XOVR_OVR_BIT = 0;
  localparam int unsigned PM_AUTO_XOVR_BIT = 1;
  localparam int unsigned PM_MAN_XOVR_BIT = 2;
  localparam int unsigned PM_ADV10H_BIT = 5;
  localparam int unsigned PM_ADV10F_BIT = 6;
  localparam int unsigned PM_MODE_LSB = 8;

  // soft-strap tie-off defaults
  localparam logic [1:0] IND_FUN_TIEOFF = 2'h0;
  localparam logic MAN_XOVR_TIEOFF = 1'b0;
  localparam logic SPEED_TIEOFF = 1'b1;
  localparam logic DUPLEX_TIEOFF = 1'b1;

  localparam logic [31:0] UNMAPPED_RDATA = 32'h0000_0000;

endpackage : mrsl_pkg

//--- hdl/mrsl_top.sv
// mrsl_top: single-module transceiver resets and configuration strap
// latch with loader override, reached over APB.
// assumes presetn is the power-on / external pin reset, strap pins
// are asynchronous, and the loader runs elsewhere on pclk.
//
// Implementation choices: the placing of the registers and the APB register port.
`timescale 1ns/10ps

// Functional notes
// - module reset touches target only, no strap/loader
// - port b reset via control or basic bit
// - port b bits read set, clear after 110us
// - port a reset via control or basic bit
// - port a bits clear after 110us, pollable
// - power-down exit auto-resets, registers kept
// - basic-bit reset keeps not-auto-reset bits
// - emulated reset from any of three bits
// - emulated bits read set, clear after 1us
// - straps captured only by pin/power reset
// - soft-straps captured at reset release
// - loader overrides soft-straps, never hard-straps
// - pinless soft-strap takes tie-off default
// - no memory: digital/reload restores captured straps
// - digital/reload never resamples strap pins
// - one indicator strap sets all eight enables
// - function strap sets function bits, tie-off zero
// - crossover strap ignored when override set
// - manual strap picks straight/crossed when auto and override low
// - negotiation strap sets enable, speed, duplex, mode
// - digital reset starts loader, spares transceivers
module mrsl_top #(
  parameter int unsigned XCVR_CYCLES = mrsl_pkg::XCVR_RST_CYC,
  parameter int unsigned EMU_CYCLES = mrsl_pkg::EMU_RST_CYC
) (
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // strap pins (asynchronous)
  input wire logic indicator_enable_strap,
  input wire logic auto_xover_strap,
  input wire logic negotiation_strap,
  input wire logic hard_strap,
  // non-volatile memory loader
  input wire logic mem_present,
  input wire logic loader_wr,
  input wire logic [mrsl_pkg::IND_EN_W-1:0] loader_ind_en,
  input wire logic [mrsl_pkg::IND_FUN_W-1:0] loader_ind_fun,
  input wire logic loader_auto_xover,
  input wire logic loader_man_xover,
  input wire logic loader_neg,
  // transceiver power-down exit events
  input wire logic port_a_pd_exit,
  input wire logic port_b_pd_exit,
  // module resets and loader start
  output logic port_a_xcvr_rst,
  output logic port_b_xcvr_rst,
  output logic emulated_xcvr_rst,
  output logic digital_rst,
  output logic loader_start,
  // resolved configuration
  output logic [mrsl_pkg::IND_EN_W-1:0] indicator_enable_bits,
  output logic [mrsl_pkg::IND_FUN_W-1:0] indicator_function_bits,
  output logic xover_auto_en,
  output logic xover_crossed,
  output logic negotiation_enable_bit,
  output logic speed_select_low_bit,
  output logic duplex_select_bit,
  output logic [2:0] xcvr_mode,
  output logic hard_strap_val
);
  import mrsl_pkg::*;

  if (XCVR_CYCLES < 1 || XCVR_CYCLES >= (1 << CNT_W) ||
      EMU_CYCLES < 1 || EMU_CYCLES >= (1 << CNT_W)) begin : g_bad_cycles
    $error("mrsl_top: reset cycle counts out of range");
  end

  // strap pin synchronisers, free-running: second stage already holds
  // the pin levels at the first edge after release (presetn >= 2 clocks)
  logic [3:0] strap_s1_r;
  logic [3:0] strap_s2_r;
  always_ff @(posedge pclk) begin
    strap_s1_r <= {hard_strap, negotiation_strap, auto_xover_strap,
                   indicator_enable_strap};
    strap_s2_r <= strap_s1_r;
  end

  // apb decode
  logic wr_en;
  logic rd_en;
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign pready = 1'b1;

  function automatic logic hit(input logic [7:0] ofs, input logic [7:0] a);
    hit = (a == ofs);
  endfunction : hit

  // per-module reset timers
  logic [CNT_W-1:0] cnt_a_r, cnt_a_nxt;
  logic [CNT_W-1:0] cnt_b_r, cnt_b_nxt;
  logic [CNT_W-1:0] cnt_e_r, cnt_e_nxt;
  logic busy_a_r, busy_a_nxt;
  logic busy_b_r, busy_b_nxt;
  logic busy_e_r, busy_e_nxt;
  logic pd_a_r, pd_a_nxt;
  logic pd_b_r, pd_b_nxt;
  logic loop_a_r, loop_a_nxt;
  logic loop_b_r, loop_b_nxt;
  logic pd_rst_a_r, pd_rst_a_nxt;
  logic pd_rst_b_r, pd_rst_b_nxt;
  logic dig_r, dig_nxt;
  logic ld_r, ld_nxt;
  logic start_a, start_b, start_e;

  // strap capture state
  logic latched_r, latched_nxt;
  logic lat_ind_en_r, lat_ind_en_nxt;
  logic lat_auto_r, lat_auto_nxt;
  logic lat_neg_r, lat_neg_nxt;
  logic lat_hard_r, lat_hard_nxt;
  // soft-strap working values
  logic [IND_EN_W-1:0] ind_en_r, ind_en_nxt;
  logic [IND_FUN_W-1:0] ind_fun_r, ind_fun_nxt;
  logic auto_r, auto_nxt;
  logic man_r, man_nxt;
  logic neg_r, neg_nxt;
  logic xovr_ovr_r, xovr_ovr_nxt;
  logic restore;

  always_comb begin
    start_a = wr_en && ((hit(RESET_CONTROL_OFS, paddr) &&
              pwdata[RC_PORT_A_BIT]) || (hit(PORT_A_BASIC_OFS, paddr) &&
              pwdata[BC_RESET_BIT]));
    start_b = wr_en && ((hit(RESET_CONTROL_OFS, paddr) &&
              pwdata[RC_PORT_B_BIT]) || (hit(PORT_B_BASIC_OFS, paddr) &&
              pwdata[BC_RESET_BIT]));
    start_e = wr_en && ((hit(RESET_CONTROL_OFS, paddr) &&
              pwdata[RC_EMU_BIT]) || (hit(POWER_MGMT_OFS, paddr) &&
              pwdata[PM_EMU_BIT]) || (hit(EMU_BASIC_OFS, paddr) &&
              pwdata[BC_RESET_BIT]));

    cnt_a_nxt = cnt_a_r;
    busy_a_nxt = busy_a_r;
    if (start_a) begin
      busy_a_nxt = 1'b1;
      cnt_a_nxt = CNT_W'(XCVR_CYCLES - 1);
    end else if (busy_a_r) begin
      if (cnt_a_r == '0) busy_a_nxt = 1'b0;
      else cnt_a_nxt = cnt_a_r - 1'b1;
    end
    cnt_b_nxt = cnt_b_r;
    busy_b_nxt = busy_b_r;
    if (start_b) begin
      busy_b_nxt = 1'b1;
      cnt_b_nxt = CNT_W'(XCVR_CYCLES - 1);
    end else if (busy_b_r) begin
      if (cnt_b_r == '0) busy_b_nxt = 1'b0;
      else cnt_b_nxt = cnt_b_r - 1'b1;
    end
    cnt_e_nxt = cnt_e_r;
    busy_e_nxt = busy_e_r;
    if (start_e) begin
      busy_e_nxt = 1'b1;
      cnt_e_nxt = CNT_W'(EMU_CYCLES - 1);
    end else if (busy_e_r) begin
      if (cnt_e_r == '0) busy_e_nxt = 1'b0;
      else cnt_e_nxt = cnt_e_r - 1'b1;
    end

    // power-down controls; a basic-bit reset leaves loopback (kept bit)
    pd_a_nxt = pd_a_r;
    pd_b_nxt = pd_b_r;
    loop_a_nxt = loop_a_r;
    loop_b_nxt = loop_b_r;
    if (wr_en && hit(POWER_MGMT_OFS, paddr)) begin
      pd_a_nxt = pwdata[PM_PD_A_BIT];
      pd_b_nxt = pwdata[PM_PD_B_BIT];
    end
    if (wr_en && hit(PORT_A_BASIC_OFS, paddr))
      loop_a_nxt = pwdata[BC_LOOP_BIT];
    if (wr_en && hit(PORT_B_BASIC_OFS, paddr))
      loop_b_nxt = pwdata[BC_LOOP_BIT];
    // one-cycle internal reset on power-down exit, no register reload
    pd_rst_a_nxt = port_a_pd_exit || (pd_a_r && !pd_a_nxt);
    pd_rst_b_nxt = port_b_pd_exit || (pd_b_r && !pd_b_nxt);

    dig_nxt = wr_en && hit(RESET_CONTROL_OFS, paddr) &&
              pwdata[RC_DIGITAL_BIT];
    ld_nxt = dig_nxt || (wr_en && hit(MEM_COMMAND_OFS, paddr) &&
             pwdata[MC_RELOAD_BIT]);
  end

  // capture once, at the first edge after release of presetn
  always_comb begin
    latched_nxt = 1'b1;
    lat_ind_en_nxt = lat_ind_en_r;
    lat_auto_nxt = lat_auto_r;
    lat_neg_nxt = lat_neg_r;
    lat_hard_nxt = lat_hard_r;
    if (!latched_r) begin
      lat_ind_en_nxt = strap_s2_r[0];
      lat_auto_nxt = strap_s2_r[1];
      lat_neg_nxt = strap_s2_r[2];
      lat_hard_nxt = strap_s2_r[3];
    end
  end

  // restore on digital reset / reload with no usable memory
  assign restore = ld_r && !mem_present;

  always_comb begin
    ind_en_nxt = ind_en_r;
    ind_fun_nxt = ind_fun_r;
    auto_nxt = auto_r;
    man_nxt = man_r;
    neg_nxt = neg_r;
    xovr_ovr_nxt = xovr_ovr_r;
    if (!latched_r || restore) begin
      ind_en_nxt = {IND_EN_W{latched_r ? lat_ind_en_r :
                             strap_s2_r[0]}};
      ind_fun_nxt = IND_FUN_TIEOFF;
      auto_nxt = latched_r ? lat_auto_r : strap_s2_r[1];
      man_nxt = MAN_XOVR_TIEOFF;
      neg_nxt = latched_r ? lat_neg_r : strap_s2_r[2];
    end else if (loader_wr && mem_present) begin
      ind_en_nxt = loader_ind_en;
      ind_fun_nxt = loader_ind_fun;
      auto_nxt = loader_auto_xover;
      man_nxt = loader_man_xover;
      neg_nxt = loader_neg;
    end
    if (wr_en && hit(INDICATOR_CFG_OFS, paddr)) begin
      ind_en_nxt = pwdata[IC_EN_LSB +: IND_EN_W];
      ind_fun_nxt = pwdata[IC_FUN_LSB +: IND_FUN_W];
    end
    if (wr_en && hit(PORT_A_MODE_OFS, paddr))
      xovr_ovr_nxt = pwdata[PM_XOVR_OVR_BIT];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_a_r <= '0;
      cnt_b_r <= '0;
      cnt_e_r <= '0;
      busy_a_r <= 1'b0;
      busy_b_r <= 1'b0;
      busy_e_r <= 1'b0;
      pd_a_r <= 1'b0;
      pd_b_r <= 1'b0;
      loop_a_r <= 1'b0;
      loop_b_r <= 1'b0;
      pd_rst_a_r <= 1'b0;
      pd_rst_b_r <= 1'b0;
      dig_r <= 1'b0;
      ld_r <= 1'b0;
      latched_r <= 1'b0;
      lat_ind_en_r <= 1'b0;
      lat_auto_r <= 1'b0;
      lat_neg_r <= 1'b0;
      lat_hard_r <= 1'b0;
      ind_en_r <= '0;
      ind_fun_r <= '0;
      auto_r <= 1'b0;
      man_r <= 1'b0;
      neg_r <= 1'b0;
      xovr_ovr_r <= 1'b0;
    end else begin
      cnt_a_r <= cnt_a_nxt;
      cnt_b_r <= cnt_b_nxt;
      cnt_e_r <= cnt_e_nxt;
      busy_a_r <= busy_a_nxt;
      busy_b_r <= busy_b_nxt;
      busy_e_r <= busy_e_nxt;
      pd_a_r <= pd_a_nxt;
      pd_b_r <= pd_b_nxt;
      loop_a_r <= loop_a_nxt;
      loop_b_r <= loop_b_nxt;
      pd_rst_a_r <= pd_rst_a_nxt;
      pd_rst_b_r <= pd_rst_b_nxt;
      dig_r <= dig_nxt;
      ld_r <= ld_nxt;
      latched_r <= latched_nxt;
      lat_ind_en_r <= lat_ind_en_nxt;
      lat_auto_r <= lat_auto_nxt;
      lat_neg_r <= lat_neg_nxt;
      lat_hard_r <= lat_hard_nxt;
      ind_en_r <= ind_en_nxt;
      ind_fun_r <= ind_fun_nxt;
      auto_r <= auto_nxt;
      man_r <= man_nxt;
      neg_r <= neg_nxt;
      xovr_ovr_r <= xovr_ovr_nxt;
    end
  end

  // module reset outputs: each drives only its own target
  assign port_a_xcvr_rst = busy_a_r || pd_rst_a_r;
  assign port_b_xcvr_rst = busy_b_r || pd_rst_b_r;
  assign emulated_xcvr_rst = busy_e_r;
  assign digital_rst = dig_r;
  assign loader_start = ld_r;

  // resolved configuration
  assign indicator_enable_bits = ind_en_r;
  assign indicator_function_bits = ind_fun_r;
  assign xover_auto_en = !xovr_ovr_r && auto_r;
  assign xover_crossed = !xovr_ovr_r && !auto_r && man_r;
  assign negotiation_enable_bit = neg_r;
  assign speed_select_low_bit = neg_r ? 1'b1 : SPEED_TIEOFF;
  assign duplex_select_bit = neg_r ? 1'b1 : DUPLEX_TIEOFF;
  assign xcvr_mode = neg_r ? 3'h7 : {1'b0, SPEED_TIEOFF, DUPLEX_TIEOFF};
  assign hard_strap_val = lat_hard_r;

  // register read mux; emulated bits share one status
  logic [31:0] rdata_c;
  always_comb begin
    rdata_c = UNMAPPED_RDATA;
    case (paddr)
      RESET_CONTROL_OFS: begin
        rdata_c[RC_PORT_A_BIT] = busy_a_r;
        rdata_c[RC_PORT_B_BIT] = busy_b_r;
        rdata_c[RC_EMU_BIT] = busy_e_r;
      end
      POWER_MGMT_OFS: begin
        rdata_c[PM_EMU_BIT] = busy_e_r;
        rdata_c[PM_PD_A_BIT] = pd_a_r;
        rdata_c[PM_PD_B_BIT] = pd_b_r;
      end
      PORT_A_BASIC_OFS: begin
        rdata_c[BC_RESET_BIT] = busy_a_r;
        rdata_c[BC_LOOP_BIT] = loop_a_r;
        rdata_c[BC_NEG_BIT] = neg_r;
        rdata_c[BC_SPEED_BIT] = speed_select_low_bit;
        rdata_c[BC_DUPLEX_BIT] = duplex_select_bit;
      end
      PORT_B_BASIC_OFS: begin
        rdata_c[BC_RESET_BIT] = busy_b_r;
        rdata_c[BC_LOOP_BIT] = loop_b_r;
      end
      EMU_BASIC_OFS: rdata_c[BC_RESET_BIT] = busy_e_r;
      INDICATOR_CFG_OFS: begin
        rdata_c[IC_EN_LSB +: IND_EN_W] = ind_en_r;
        rdata_c[IC_FUN_LSB +: IND_FUN_W] = ind_fun_r;
      end
      PORT_A_MODE_OFS: begin
        rdata_c[PM_XOVR_OVR_BIT] = xovr_ovr_r;
        rdata_c[PM_AUTO_XOVR_BIT] = auto_r;
        rdata_c[PM_MAN_XOVR_BIT] = man_r;
        rdata_c[PM_ADV10H_BIT] = neg_r || speed_select_low_bit;
        rdata_c[PM_ADV10F_BIT] = neg_r || duplex_select_bit;
        rdata_c[PM_MODE_LSB +: 3] = xcvr_mode;
      end
      STRAP_STATUS_OFS: begin
        rdata_c[0] = lat_ind_en_r;
        rdata_c[1] = lat_auto_r;
        rdata_c[2] = lat_neg_r;
        rdata_c[3] = lat_hard_r;
      end
      default: rdata_c = UNMAPPED_RDATA;
    endcase
  end

  logic [31:0] prdata_r, prdata_nxt;
  assign prdata_nxt = (psel && !penable && !pwrite) ? rdata_c : prdata_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prdata_r <= '0;
    else prdata_r <= prdata_nxt;
  end
  assign prdata = prdata_r;
  assign pslverr = 1'b0;
  logic unused_rd;
  assign unused_rd = rd_en;

endmodule : mrsl_top

//--- bench/mrsl_top_checker.sv
// mrsl_checker: port-level timing checks for mrsl_top, bound below.
// assumes one pclk domain and async active-low presetn.
`timescale 1ns/10ps
module mrsl_checker #(
  parameter int unsigned XCVR_CYCLES = mrsl_pkg::XCVR_RST_CYC,
  parameter int unsigned EMU_CYCLES = mrsl_pkg::EMU_RST_CYC
) (
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  // events and resets
  input wire logic port_a_pd_exit,
  input wire logic port_a_xcvr_rst,
  input wire logic port_b_xcvr_rst,
  input wire logic emulated_xcvr_rst,
  input wire logic digital_rst,
  input wire logic loader_start
);
  import mrsl_pkg::*;
  logic acc, ctl, trig_a, trig_b, trig_e, trig_d;
  logic [31:0] len_a_r, len_a_nxt;
  assign acc = psel && penable && pwrite;
  assign ctl = acc && paddr == RESET_CONTROL_OFS;
  assign trig_a = ctl && pwdata[RC_PORT_A_BIT] ||
    acc && paddr == PORT_A_BASIC_OFS && pwdata[BC_RESET_BIT];
  assign trig_b = ctl && pwdata[RC_PORT_B_BIT] ||
    acc && paddr == PORT_B_BASIC_OFS && pwdata[BC_RESET_BIT];
  assign trig_e = ctl && pwdata[RC_EMU_BIT] ||
    acc && paddr == POWER_MGMT_OFS && pwdata[PM_EMU_BIT] ||
    acc && paddr == EMU_BASIC_OFS && pwdata[BC_RESET_BIT];
  assign trig_d = ctl && pwdata[RC_DIGITAL_BIT];
  // run length of the port a reset level
  always_comb begin
    len_a_nxt = port_a_xcvr_rst ? len_a_r + 32'h1 : 32'h0;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      len_a_r <= 32'h0;
    end else begin
      len_a_r <= len_a_nxt;
    end
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  property p_a_start; trig_a |-> ##[1:2] port_a_xcvr_rst; endproperty
  a_a_start: assert property (p_a_start)
    else $error("port a reset did not start");
  property p_b_start; trig_b |-> ##[1:2] port_b_xcvr_rst; endproperty
  a_b_start: assert property (p_b_start)
    else $error("port b reset did not start");
  property p_e_start; trig_e |-> ##[1:2] emulated_xcvr_rst; endproperty
  a_e_start: assert property (p_e_start)
    else $error("emulated reset did not start");
  property p_e_hold;
    $rose(emulated_xcvr_rst) |=> emulated_xcvr_rst [*8];
  endproperty
  a_e_hold: assert property (p_e_hold)
    else $error("emulated reset too short");
  property p_a_len;
    $fell(port_a_xcvr_rst) |-> len_a_r == 32'h1 || len_a_r == XCVR_CYCLES;
  endproperty
  a_a_len: assert property (p_a_len)
    else $error("port a reset length wrong");
  property p_pd_exit; port_a_pd_exit |-> ##[1:2] port_a_xcvr_rst; endproperty
  a_pd_exit: assert property (p_pd_exit)
    else $error("no reset after power-down exit");
  property p_no_loader;
    (trig_a || trig_b || trig_e) && !trig_d
      |=> (!loader_start && !digital_rst) [*3];
  endproperty
  a_no_loader: assert property (p_no_loader)
    else $error("module reset started loader");
  property p_digital;
    trig_d |-> ##[1:3] digital_rst ##[0:3] loader_start;
  endproperty
  a_digital: assert property (p_digital)
    else $error("digital reset or loader start missing");
  c_digital: cover property (trig_d);
  c_emu_done: cover property ($fell(emulated_xcvr_rst));
  c_pd_exit: cover property (port_a_pd_exit ##[1:2] port_a_xcvr_rst);
endmodule : mrsl_checker

bind mrsl_top mrsl_checker #(
  .XCVR_CYCLES(XCVR_CYCLES),
  .EMU_CYCLES(EMU_CYCLES)
) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .port_a_pd_exit(port_a_pd_exit), .port_a_xcvr_rst(port_a_xcvr_rst),
  .port_b_xcvr_rst(port_b_xcvr_rst), .emulated_xcvr_rst(emulated_xcvr_rst),
  .digital_rst(digital_rst), .loader_start(loader_start)
);

//--- bench/mrsl_top_tb_top.sv
// mrsl_top_tb_top: directed bench for mrsl_top.
// assumes shortened reset counts; the checker binds itself.
`timescale 1ns/10ps
module mrsl_top_tb_top;
  import mrsl_pkg::*;
  localparam int unsigned XC = 50;
  localparam int unsigned EC = 20;
  typedef struct {logic [7:0] a; logic [31:0] d, keep; int tgt;} mrsl_row_s;
  logic pclk = 1'b0, presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd, msk;
  logic pready, pslverr, xover_auto_en, xover_crossed;
  logic indicator_enable_strap = 1'b1, auto_xover_strap = 1'b0;
  logic negotiation_strap = 1'b1, hard_strap = 1'b1;
  logic mem_present = 1'b0, loader_wr = 1'b0, loader_neg = 1'b0;
  logic [7:0] loader_ind_en = 8'h0;
  logic [1:0] loader_ind_fun = 2'h0;
  logic loader_auto_xover = 1'b0, loader_man_xover = 1'b0;
  logic port_a_pd_exit = 1'b0, port_b_pd_exit = 1'b0;
  logic port_a_xcvr_rst, port_b_xcvr_rst, emulated_xcvr_rst;
  logic digital_rst, loader_start, negotiation_enable_bit, hard_strap_val;
  logic speed_select_low_bit, duplex_select_bit;
  logic [2:0] xcvr_mode;
  logic [7:0] indicator_enable_bits;
  logic [1:0] indicator_function_bits;
  logic [2:0] rsts, seen;
  logic dig_seen, ld_seen;
  int unsigned run_len [3], last_len [3];
  int n_errors = 0, checks_done = 0, cycles = 0;
  mrsl_row_s rows [7] = '{
    '{RESET_CONTROL_OFS, 32'h2, 32'h0, 0},
    '{PORT_A_BASIC_OFS, 32'hC000, 32'h4000, 0},
    '{RESET_CONTROL_OFS, 32'h4, 32'h0, 1},
    '{PORT_B_BASIC_OFS, 32'h8000, 32'h0, 1},
    '{RESET_CONTROL_OFS, 32'h8, 32'h0, 2},
    '{POWER_MGMT_OFS, 32'h1, 32'h0, 2},
    '{EMU_BASIC_OFS, 32'h8000, 32'h0, 2}};
  logic [7:0] em_a [3] = '{RESET_CONTROL_OFS, POWER_MGMT_OFS, EMU_BASIC_OFS};
  int em_b [3] = '{RC_EMU_BIT, PM_EMU_BIT, BC_RESET_BIT};

  mrsl_top #(.XCVR_CYCLES(XC), .EMU_CYCLES(EC)) u_dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .indicator_enable_strap, .auto_xover_strap,
    .negotiation_strap, .hard_strap, .mem_present, .loader_wr,
    .loader_ind_en, .loader_ind_fun, .loader_auto_xover, .loader_man_xover,
    .loader_neg, .port_a_pd_exit, .port_b_pd_exit, .port_a_xcvr_rst,
    .port_b_xcvr_rst, .emulated_xcvr_rst, .digital_rst, .loader_start,
    .indicator_enable_bits, .indicator_function_bits, .xover_auto_en,
    .xover_crossed, .negotiation_enable_bit, .speed_select_low_bit,
    .duplex_select_bit, .xcvr_mode, .hard_strap_val);

  assign rsts = {emulated_xcvr_rst, port_b_xcvr_rst, port_a_xcvr_rst};
  always #2.5 pclk = ~pclk;

  // reset pulse lengths, stray activity and the hang limit
  always @(posedge pclk) begin
    cycles++;
    for (int k = 0; k < 3; k++) begin
      if (rsts[k] === 1'b1) begin
        run_len[k]++;
        seen[k] = 1'b1;
      end else if (run_len[k] != 0) begin
        last_len[k] = run_len[k];
        run_len[k] = 0;
      end
    end
    if (digital_rst === 1'b1) dig_seen = 1'b1;
    if (loader_start === 1'b1) ld_seen = 1'b1;
    if (cycles > 20000) begin
      n_errors++;
      stop_test();
    end
  end

  task automatic check(input string what, input logic [31:0] got,
      input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
    end
  endtask : check

  task automatic stop_test();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : stop_test

  task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic strap_chk(input logic [7:0] en, input logic [1:0] fn,
      input logic au, input logic cr, input logic ng, input logic hd);
    check("ind en", indicator_enable_bits, en);
    check("ind fun", indicator_function_bits, fn);
    check("auto xover", xover_auto_en, au);
    check("crossed", xover_crossed, cr);
    check("negotiation", negotiation_enable_bit, ng);
    check("hard strap", hard_strap_val, hd);
  endtask : strap_chk

  initial begin
    seen = 3'h0;
    dig_seen = 1'b0;
    ld_seen = 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    repeat (10) @(posedge pclk);
    strap_chk(8'hFF, 2'h0, 1'b0, 1'b0, 1'b1, 1'b1);
    // pins move; captured values must not follow them
    indicator_enable_strap <= 1'b0;
    auto_xover_strap <= 1'b1;
    negotiation_strap <= 1'b0;
    hard_strap <= 1'b0;
    ld_seen = 1'b0;
    apb(1'b1, RESET_CONTROL_OFS, 32'h1);
    repeat (8) @(posedge pclk);
    check("digital", {dig_seen, ld_seen, seen}, 32'h18);
    strap_chk(8'hFF, 2'h0, 1'b0, 1'b0, 1'b1, 1'b1);
    mem_present <= 1'b1;
    loader_wr <= 1'b1;
    loader_ind_en <= 8'hA5;
    loader_ind_fun <= 2'h2;
    loader_man_xover <= 1'b1;
    @(posedge pclk);
    loader_wr <= 1'b0;
    repeat (4) @(posedge pclk);
    strap_chk(8'hA5, 2'h2, 1'b0, 1'b1, 1'b0, 1'b1);
    mem_present <= 1'b0;
    dig_seen = 1'b0;
    ld_seen = 1'b0;
    apb(1'b1, MEM_COMMAND_OFS, 32'h1);
    repeat (8) @(posedge pclk);
    check("reload", {dig_seen, ld_seen}, 32'h1);
    strap_chk(8'hFF, 2'h0, 1'b0, 1'b0, 1'b1, 1'b1);
    presetn <= 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    repeat (10) @(posedge pclk);
    check("fresh ind", indicator_enable_bits, 32'h0);
    check("fresh auto", xover_auto_en, 32'h1);
    check("fresh neg", negotiation_enable_bit, 32'h0);
    check("fresh hard", hard_strap_val, 32'h0);
    check("fresh spd dpx", {speed_select_low_bit, duplex_select_bit},
      {SPEED_TIEOFF, DUPLEX_TIEOFF});
    check("fresh mode", xcvr_mode,
      {1'b0, SPEED_TIEOFF, DUPLEX_TIEOFF});
    apb(1'b1, PORT_A_MODE_OFS, 32'h1);
    repeat (2) @(posedge pclk);
    check("override", xover_auto_en, 32'h0);
    foreach (rows[i]) begin
      msk = rows[i].d & ~rows[i].keep;
      seen = 3'h0;
      ld_seen = 1'b0;
      last_len = '{0, 0, 0};
      apb(1'b1, rows[i].a, rows[i].d);
      apb(1'b0, rows[i].a, 32'h0);
      check("busy bit", rd & msk, msk);
      if (rows[i].tgt == 2) begin
        foreach (em_a[j]) begin
          apb(1'b0, em_a[j], 32'h0);
          check("shared busy", rd[em_b[j]], 32'h1);
        end
      end
      do apb(1'b0, rows[i].a, 32'h0); while ((rd & msk) !== 32'h0);
      check("kept bits", rd & rows[i].keep, rows[i].keep);
      repeat (3) @(posedge pclk);
      check("length", last_len[rows[i].tgt],
        rows[i].tgt == 2 ? EC : XC);
      check("only target", {ld_seen, seen},
        32'h1 << rows[i].tgt);
    end
    port_a_pd_exit <= 1'b1;
    port_b_pd_exit <= 1'b1;
    @(posedge pclk);
    port_a_pd_exit <= 1'b0;
    port_b_pd_exit <= 1'b0;
    repeat (4) @(posedge pclk);
    check("pd exit a", last_len[0], 32'h1);
    check("pd exit b", last_len[1], 32'h1);
    apb(1'b0, PORT_A_BASIC_OFS, 32'h0);
    check("pd keeps regs", rd & 32'hC000, 32'h4000);
    apb(1'b1, 8'h3C, 32'hFFFF_FFFF);
    apb(1'b0, 8'h3C, 32'h0);
    check("unmapped", rd, UNMAPPED_RDATA);
    check("no error", pslverr, 32'h0);
    stop_test();
  end
endmodule : mrsl_top_tb_top
